// ### ivfr_pkg.sv
// package for the input-voltage fault reaction block
// holds command codes, field positions, reset values, timing and carrier types
package ivfr_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_OV_FAULT_THRESHOLD = 8'h55;
  localparam logic [7:0] CMD_OV_FAULT_REACTION = 8'h56;
  localparam logic [7:0] CMD_OV_WARN_THRESHOLD = 8'h57;
  localparam logic [7:0] CMD_UV_WARN_THRESHOLD = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT_THRESHOLD = 8'h59;
  localparam logic [7:0] CMD_UV_FAULT_REACTION = 8'h5a;

  // ==========================================================================
  // reaction byte fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int COUNT_HI = 5;
  localparam int COUNT_LO = 3;
  localparam int TIME_HI = 2;
  localparam int TIME_LO = 0;
  localparam logic [1:0] MODE_RETRY = 2'h2;
  localparam logic [1:0] MODE_RESUME = 2'h3;
  localparam logic [2:0] COUNT_NONE = 3'h0;
  localparam logic [2:0] COUNT_FOREVER = 3'h7;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_OV_FAULT_REACTION = 8'hc0;
  localparam logic [7:0] RST_UV_FAULT_REACTION = 8'hc0;
  localparam logic [15:0] RST_OV_FAULT_THRESHOLD = 16'hffff;
  localparam logic [15:0] RST_OV_WARN_THRESHOLD = 16'hffff;
  localparam logic [15:0] RST_UV_WARN_THRESHOLD = 16'h0000;
  localparam logic [15:0] RST_UV_FAULT_THRESHOLD = 16'h0000;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int RETRY_STEP_MS = 35;
  localparam int RETRY_STEP_CYCLES = RETRY_STEP_MS * CLK_MHZ * 1000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {ST_RUN, ST_DELAY, ST_LATCH, ST_RESUME} ivfr_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [7:0] code;
    logic [15:0] data;
  } ivfr_cmd_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [15:0] data;
  } ivfr_rsp_t;

endpackage : ivfr_pkg

// ### ivfr_retry_timer.sv
// retry delay timer: counts a number of fixed-length steps, then pulses
// assumes a free-running clk and a clock enable that freezes it
`timescale 1ns/100ps
`default_nettype none

module ivfr_retry_timer
  import ivfr_pkg::*;
#(
  parameter int STEP_CYCLES = RETRY_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] steps,
  output logic busy,
  output logic expired
);

  // ==========================================================================
  // counters
  logic [31:0] pre;
  logic [3:0] remaining;
  wire logic pre_wrap = (pre == 32'(STEP_CYCLES - 1));
  wire logic last_step = pre_wrap && (remaining == 4'h1);

  always_ff @(posedge clk) begin
    if (rst) begin
      pre <= 32'h0;
      remaining <= 4'h0;
      busy <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (start) begin
        pre <= 32'h0;
        remaining <= steps;
        busy <= 1'b1;
      end else if (abort) begin
        busy <= 1'b0;
        remaining <= 4'h0;
      end else if (busy) begin
        pre <= pre_wrap ? 32'h0 : pre + 32'h1;
        if (pre_wrap) begin
          remaining <= remaining - 4'h1;
        end
        if (last_step) begin
          busy <= 1'b0;
          expired <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_step_load: assert property (ce && start |=> busy && remaining == $past(steps) && pre == 32'h0)
    else $error("retry timer did not load its step count");
  a_expiry_point: assert property (ce && busy && !start && !abort && last_step |=> expired && !busy)
    else $error("retry timer missed its expiry");

endmodule : ivfr_retry_timer
`default_nettype wire

// ### ivfr_top.sv
// input-voltage fault reaction: thresholds, reaction bytes, retry and resume control
// assumes commands arrive already decoded from the serial link, and vin in the
// same linear encoding and exponent as the thresholds
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - retry mode: switch off, then restart per count
// - over-voltage resume below the warning threshold
// - under-voltage resume above the warning threshold
// - any reaction pulls alert low, sets flag
// - count zero: stay off until cleared
// - count seven: retry without any limit
// - otherwise retry exactly the programmed count
// - retry spacing is (time plus one) times 35ms
// - word over-voltage warning threshold at 0x57
// - word under-voltage warning threshold at 0x58
// - word under-voltage fault threshold at 0x59
// - over-voltage reaction byte at 0x56
// - under-voltage reaction byte at 0x5a
// - word over-voltage fault threshold at 0x55
module ivfr_top
  import ivfr_pkg::*;
#(
  parameter int STEP_CYCLES = RETRY_STEP_CYCLES,
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire ivfr_cmd_t cmd,
  output ivfr_rsp_t rsp,
  input wire logic [15:0] vin,
  input wire logic enable_req,
  input wire logic other_shutdown,
  input wire logic clear_faults,
  output logic power_enable,
  output logic alert_line_n,
  output logic ov_fault_flag,
  output logic uv_fault_flag,
  output logic ov_warning,
  output logic uv_warning
);

  // ==========================================================================
  // command decode
  logic [15:0] ov_fault_threshold;
  logic [15:0] ov_warn_threshold;
  logic [15:0] uv_warn_threshold;
  logic [15:0] uv_fault_threshold;
  logic [7:0] ov_reaction;
  logic [7:0] uv_reaction;

  wire logic hit_ovf = (cmd.code == CMD_OV_FAULT_THRESHOLD);
  wire logic hit_ovw = (cmd.code == CMD_OV_WARN_THRESHOLD);
  wire logic hit_uvw = (cmd.code == CMD_UV_WARN_THRESHOLD);
  wire logic hit_uvf = (cmd.code == CMD_UV_FAULT_THRESHOLD);
  wire logic hit_ovr = (cmd.code == CMD_OV_FAULT_REACTION);
  wire logic hit_uvr = (cmd.code == CMD_UV_FAULT_REACTION);
  wire logic hit_word = hit_ovf || hit_ovw || hit_uvw || hit_uvf;
  wire logic hit_byte = hit_ovr || hit_uvr;
  // transfer size must match the command: words for thresholds, bytes for reactions
  wire logic size_ok = (hit_word && cmd.word) || (hit_byte && !cmd.word);
  wire logic take = ce && cmd.valid && size_ok;
  wire logic wr = take && cmd.write;

  wire logic [15:0] rd_word =
    hit_ovf ? ov_fault_threshold :
    hit_ovw ? ov_warn_threshold :
    hit_uvw ? uv_warn_threshold :
    hit_uvf ? uv_fault_threshold : 16'h0000;
  wire logic [15:0] rd_byte =
    hit_ovr ? {8'h00, ov_reaction} :
    hit_uvr ? {8'h00, uv_reaction} : 16'h0000;
  wire logic [15:0] rd_data = cmd.word ? rd_word : rd_byte;

  // ==========================================================================
  // register file
  always_ff @(posedge clk) begin
    if (rst) begin
      ov_fault_threshold <= RST_OV_FAULT_THRESHOLD;
      ov_warn_threshold <= RST_OV_WARN_THRESHOLD;
      uv_warn_threshold <= RST_UV_WARN_THRESHOLD;
      uv_fault_threshold <= RST_UV_FAULT_THRESHOLD;
      ov_reaction <= RST_OV_FAULT_REACTION;
      uv_reaction <= RST_UV_FAULT_REACTION;
    end else if (wr) begin
      if (hit_ovf) ov_fault_threshold <= cmd.data;
      if (hit_ovw) ov_warn_threshold <= cmd.data;
      if (hit_uvw) uv_warn_threshold <= cmd.data;
      if (hit_uvf) uv_fault_threshold <= cmd.data;
      if (hit_ovr) ov_reaction <= cmd.data[7:0];
      if (hit_uvr) uv_reaction <= cmd.data[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp <= '0;
    end else if (ce) begin
      rsp.valid <= cmd.valid;
      rsp.error <= cmd.valid && !size_ok;
      rsp.data <= (cmd.valid && !cmd.write && size_ok) ? rd_data : 16'h0000;
    end
  end

  // ==========================================================================
  // comparators, channel 0 is over-voltage, channel 1 under-voltage
  logic [CHANNELS-1:0] fault_cond;
  logic [CHANNELS-1:0] recover_cond;
  logic [7:0] reaction [CHANNELS];
  assign fault_cond[0] = (vin > ov_fault_threshold);
  assign fault_cond[1] = (vin < uv_fault_threshold);
  assign recover_cond[0] = (vin < ov_warn_threshold);
  assign recover_cond[1] = (vin > uv_warn_threshold);
  assign reaction[0] = ov_reaction;
  assign reaction[1] = uv_reaction;

  // ==========================================================================
  // per-channel reaction control
  ivfr_state_t st [CHANNELS];
  ivfr_state_t next_st [CHANNELS];
  logic [2:0] attempts [CHANNELS];
  logic [2:0] next_attempts [CHANNELS];
  logic [CHANNELS-1:0] event_hit;
  logic [CHANNELS-1:0] tmr_start;
  logic [CHANNELS-1:0] tmr_abort;
  logic [CHANNELS-1:0] tmr_expired;
  logic [CHANNELS-1:0] flag;
  logic [CHANNELS-1:0] next_ok;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      wire logic [1:0] mode = reaction[gi][MODE_HI:MODE_LO];
      wire logic [2:0] count = reaction[gi][COUNT_HI:COUNT_LO];
      wire logic [3:0] steps = {1'b0, reaction[gi][TIME_HI:TIME_LO]} + 4'h1;
      wire logic forever_mode = (count == COUNT_FOREVER);
      wire logic spent = (attempts[gi] + 3'h1 >= count);
      wire logic retry_again = tmr_expired[gi] && fault_cond[gi] && (forever_mode || !spent);

      // a fault is only acted on while this channel is in ST_RUN and enable_req is high
      assign event_hit[gi] = (st[gi] == ST_RUN) && enable_req && fault_cond[gi];
      assign next_ok[gi] = (next_st[gi] == ST_RUN);
      assign tmr_start[gi] = (next_st[gi] == ST_DELAY) &&
        (((st[gi] == ST_RUN) && event_hit[gi]) || ((st[gi] == ST_DELAY) && retry_again));
      assign tmr_abort[gi] = (st[gi] == ST_DELAY) && (next_st[gi] != ST_DELAY);

      always_comb begin
        next_st[gi] = st[gi];
        next_attempts[gi] = attempts[gi];
        if (other_shutdown && (st[gi] == ST_DELAY)) begin
          next_st[gi] = ST_LATCH;
        end else if (clear_faults && (st[gi] == ST_LATCH)) begin
          next_st[gi] = ST_RUN;
          next_attempts[gi] = 3'h0;
        end else if (!enable_req && (st[gi] == ST_DELAY)) begin
          next_st[gi] = ST_RUN;
          next_attempts[gi] = 3'h0;
        end else begin
          unique case (st[gi])
            ST_RUN: begin
              if (event_hit[gi] && (mode == MODE_RETRY)) begin
                next_st[gi] = (count == COUNT_NONE) ? ST_LATCH : ST_DELAY;
              end else if (event_hit[gi] && (mode == MODE_RESUME)) begin
                next_st[gi] = ST_RESUME;
              end
              // reserved modes flag the fault and keep the output running
            end
            ST_DELAY: begin
              if (tmr_expired[gi] && !fault_cond[gi]) begin
                next_st[gi] = ST_RUN;
                next_attempts[gi] = 3'h0;
              end else if (retry_again) begin
                next_attempts[gi] = forever_mode ? attempts[gi] : attempts[gi] + 3'h1;
              end else if (tmr_expired[gi]) begin
                next_st[gi] = ST_LATCH;
              end
            end
            ST_LATCH: begin
            end
            ST_RESUME: begin
              if (recover_cond[gi]) begin
                next_st[gi] = ST_RUN;
              end
            end
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          st[gi] <= ST_RUN;
          attempts[gi] <= 3'h0;
          flag[gi] <= 1'b0;
        end else if (ce) begin
          st[gi] <= next_st[gi];
          attempts[gi] <= next_attempts[gi];
          // a new fault wins over a clear in the same cycle
          flag[gi] <= event_hit[gi] || (flag[gi] && !clear_faults);
        end
      end

      ivfr_retry_timer #(
        .STEP_CYCLES(STEP_CYCLES)
      ) u_timer (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(tmr_start[gi]),
        .abort(tmr_abort[gi]),
        .steps(steps),
        .busy(),
        .expired(tmr_expired[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // outputs
  wire logic next_power = enable_req && (&next_ok);
  wire logic next_alert_n = !(|event_hit || (|flag && !clear_faults));

  always_ff @(posedge clk) begin
    if (rst) begin
      power_enable <= 1'b0;
      alert_line_n <= 1'b1;
      ov_fault_flag <= 1'b0;
      uv_fault_flag <= 1'b0;
      ov_warning <= 1'b0;
      uv_warning <= 1'b0;
    end else if (ce) begin
      power_enable <= next_power;
      alert_line_n <= next_alert_n;
      ov_fault_flag <= event_hit[0] || (flag[0] && !clear_faults);
      uv_fault_flag <= event_hit[1] || (flag[1] && !clear_faults);
      ov_warning <= !recover_cond[0];
      uv_warning <= !recover_cond[1];
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_retry_fault(int c);
    event_hit[c] && (reaction[c][MODE_HI:MODE_LO] == MODE_RETRY);
  endsequence

  a_alert_on_fault: assert property (|event_hit |=> !alert_line_n)
    else $error("alert not pulled low on fault");
  a_flag_set_wins: assert property (event_hit[0] && clear_faults |=> ov_fault_flag)
    else $error("fault flag lost against clear");
  a_retry_disable: assert property (s_retry_fault(0) or s_retry_fault(1) |=> !power_enable)
    else $error("output not disabled in retry mode");
  a_no_retry_latch: assert property (s_retry_fault(1) ##0 (reaction[1][COUNT_HI:COUNT_LO] == COUNT_NONE)
    |=> st[1] == ST_LATCH)
    else $error("zero count did not latch off");
  a_ov_resume: assert property (st[0] == ST_RESUME && recover_cond[0] && !other_shutdown
    |=> st[0] == ST_RUN)
    else $error("over-voltage channel did not resume");
  a_uv_resume: assert property (st[1] == ST_RESUME && !recover_cond[1] |=> st[1] == ST_RESUME)
    else $error("under-voltage channel resumed too early");
  a_retry_forever: assert property (st[0] == ST_DELAY && tmr_expired[0] && fault_cond[0] && enable_req &&
    !other_shutdown && reaction[0][COUNT_HI:COUNT_LO] == COUNT_FOREVER |=> st[0] == ST_DELAY)
    else $error("continuous retry stopped");
  a_retry_spent: assert property (st[0] == ST_DELAY && tmr_expired[0] && fault_cond[0] && enable_req &&
    !other_shutdown && reaction[0][COUNT_HI:COUNT_LO] != COUNT_FOREVER &&
    attempts[0] + 3'h1 >= reaction[0][COUNT_HI:COUNT_LO] |=> st[0] == ST_LATCH)
    else $error("retry count not honoured");
  a_restart_reset: assert property (st[1] == ST_DELAY && tmr_expired[1] && !fault_cond[1] && enable_req &&
    !other_shutdown |=> st[1] == ST_RUN && attempts[1] == 3'h0)
    else $error("attempt counter not reset on restart");
  a_word_write: assert property (wr && hit_ovw |=> ov_warn_threshold == $past(cmd.data))
    else $error("warning threshold write lost");
  a_byte_size: assert property (cmd.valid && hit_uvr && cmd.word |=> rsp.error)
    else $error("word access to reaction byte not refused");

endmodule : ivfr_top
`default_nettype wire

// ### ivfr_host_model.sv
// host side of the command port: issues one decoded command, waits for the answer
// assumes the bench calls xfer from one process at a time
`timescale 1ns/100ps
`default_nettype none

module ivfr_host
  import ivfr_pkg::*;
(
  input wire logic clk,
  output ivfr_cmd_t cmd,
  input wire ivfr_rsp_t rsp
);
  initial cmd = '0;

  // ==========================================================================
  // one transfer
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] code, input logic [15:0] data,
                      output ivfr_rsp_t got);
    int n;
    got = '0;
    n = 0;
    @(negedge clk);
    cmd <= '{valid: 1'b1, write: wr, word: wd, code: code, data: wd ? data : {~data[7:0], data[7:0]}};
    @(negedge clk);
    cmd <= '{valid: 1'b0, write: ~wr, word: ~wd, code: ~code, data: ~data};
    while (n < 3 && rsp.valid !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    got = rsp;
  endtask : xfer
endmodule : ivfr_host

`default_nettype wire

// ### ivfr_top_tb.sv
// self-checking bench for the input-voltage fault reaction block
// assumes a shortened retry step so delays take a few cycles
`timescale 1ns/100ps
`default_nettype none

module ivfr_top_tb;
  import ivfr_pkg::*;
  localparam int S = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic enable_req = 1'b1;
  logic other_shutdown = 1'b0;
  logic clear_faults = 1'b0;
  logic [15:0] vin = 16'h0a00;
  ivfr_cmd_t cmd;
  ivfr_rsp_t rsp;
  logic power_enable, alert_line_n, ov_fault_flag, uv_fault_flag, ov_warning, uv_warning;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] codes [6] = '{CMD_OV_FAULT_THRESHOLD, CMD_OV_FAULT_REACTION, CMD_OV_WARN_THRESHOLD,
                           CMD_UV_WARN_THRESHOLD, CMD_UV_FAULT_THRESHOLD, CMD_UV_FAULT_REACTION};

  always #5 clk = ~clk;

  ivfr_host HOST (.clk(clk), .cmd(cmd), .rsp(rsp));

  ivfr_top #(.STEP_CYCLES(S), .CHANNELS(2)) DUT (
    .clk(clk), .rst(rst), .ce(ce), .cmd(cmd), .rsp(rsp), .vin(vin), .enable_req(enable_req),
    .other_shutdown(other_shutdown), .clear_faults(clear_faults), .power_enable(power_enable),
    .alert_line_n(alert_line_n), .ov_fault_flag(ov_fault_flag), .uv_fault_flag(uv_fault_flag),
    .ov_warning(ov_warning), .uv_warning(uv_warning)
  );

  // ==========================================================================
  // expectations
  function automatic logic is_word(input logic [7:0] c);
    return !(c == CMD_OV_FAULT_REACTION || c == CMD_UV_FAULT_REACTION);
  endfunction : is_word

  function automatic logic [15:0] exp_reset(input logic [7:0] c);
    case (c)
      CMD_OV_FAULT_THRESHOLD, CMD_OV_WARN_THRESHOLD: return 16'hffff;
      CMD_OV_FAULT_REACTION, CMD_UV_FAULT_REACTION: return 16'h00c0;
      default: return 16'h0000;
    endcase
  endfunction : exp_reset

  // ==========================================================================
  // helpers
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic rd(input logic [7:0] c, input logic wd, output logic [15:0] d, output logic e);
    ivfr_rsp_t r;
    HOST.xfer(1'b0, wd, c, 16'h0000, r);
    d = r.data;
    e = r.error;
  endtask : rd

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    ivfr_rsp_t r;
    HOST.xfer(1'b1, is_word(c), c, d, r);
  endtask : wr

  task automatic clear();
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(2);
  endtask : clear

  task automatic wait_on(output int n);
    n = 0;
    while (power_enable !== 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
  endtask : wait_on

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================================
  // scenarios
  initial begin
    logic [15:0] d;
    logic [15:0] w;
    logic e;
    logic bad;
    int n;
    void'($urandom(32'ha724));
    cyc(5);
    rst = 1'b0;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      rd(codes[i], is_word(codes[i]), d, e);
      chk(d, exp_reset(codes[i]));
    end
    repeat (3) for (int i = 0; i < 6; i++) begin
      w = 16'($urandom);
      wr(codes[i], w);
      rd(codes[i], is_word(codes[i]), d, e);
      chk(d, is_word(codes[i]) ? w : {8'h00, w[7:0]});
      chk({15'h0, e}, 16'h0000);
    end
    rd(CMD_OV_FAULT_REACTION, 1'b1, d, e);
    chk({15'h0, e}, 16'h0001);
    rd(CMD_OV_WARN_THRESHOLD, 1'b0, d, e);
    chk({15'h0, e}, 16'h0001);
    rd(8'h5b, 1'b0, d, e);
    chk({15'h0, e}, 16'h0001);
    wr(CMD_OV_FAULT_THRESHOLD, 16'h0e00);
    wr(CMD_OV_WARN_THRESHOLD, 16'h0d00);
    wr(CMD_UV_WARN_THRESHOLD, 16'h0800);
    wr(CMD_UV_FAULT_THRESHOLD, 16'h0700);
    wr(CMD_UV_FAULT_REACTION, 16'h00c0);
    wr(CMD_OV_FAULT_REACTION, 16'h00c0);
    // let any delay left by the random phase run out, then drop stale flags
    cyc(8 * S + 4);
    clear();
    vin = 16'h0d00;
    cyc(3);
    chk({ov_warning, uv_warning}, 16'h0002);
    vin = 16'h0800;
    cyc(3);
    chk({ov_warning, uv_warning}, 16'h0001);
    vin = 16'h0a00;
    cyc(3);
    chk({power_enable, alert_line_n}, 16'h0003);
    for (int t = 0; t < 8; t++) begin
      wr(CMD_OV_FAULT_REACTION, {8'h00, 2'h2, 3'h1, 3'(t)});
      vin = 16'h0e01 + 16'($urandom_range(0, 255));
      cyc(1);
      vin = 16'h0a00;
      cyc(1);
      chk({power_enable, alert_line_n, ov_fault_flag}, 16'h0001);
      wait_on(n);
      chk(16'(n >= (t + 1) * S - 1 && n <= (t + 1) * S + 3), 16'h0001);
      clear();
      chk(alert_line_n, 1'b1);
    end
    wr(CMD_OV_FAULT_REACTION, 16'h0090);
    vin = 16'h0e01;
    cyc(2 * S + 6);
    vin = 16'h0a00;
    cyc(4 * S);
    chk(power_enable, 1'b0);
    clear();
    chk(power_enable, 1'b1);
    wr(CMD_OV_FAULT_REACTION, 16'h0080);
    vin = 16'h0e01;
    cyc(2);
    vin = 16'h0a00;
    cyc(3 * S);
    chk(power_enable, 1'b0);
    clear();
    chk(power_enable, 1'b1);
    wr(CMD_OV_FAULT_REACTION, 16'h00b8);
    vin = 16'h0f00;
    bad = 1'b0;
    repeat (10 * S) begin
      cyc(1);
      if (power_enable !== 1'b0) bad = 1'b1;
    end
    chk(bad, 1'b0);
    vin = 16'h0a00;
    wait_on(n);
    chk(16'(n <= S + 3), 16'h0001);
    clear();
    vin = 16'h0e01;
    cyc(3);
    other_shutdown = 1'b1;
    cyc(1);
    other_shutdown = 1'b0;
    vin = 16'h0a00;
    cyc(3 * S);
    chk(power_enable, 1'b0);
    clear();
    chk(power_enable, 1'b1);
    wr(CMD_OV_FAULT_REACTION, 16'h00c0);
    for (int ch = 0; ch < 2; ch++) begin
      vin = ch ? 16'h06ff - 16'($urandom_range(0, 255)) : 16'h0e01;
      cyc(2);
      chk({power_enable, ov_fault_flag, uv_fault_flag}, ch ? 16'h0001 : 16'h0002);
      vin = ch ? 16'h0800 : 16'h0d00;
      cyc(4);
      chk(power_enable, 1'b0);
      vin = ch ? 16'h0801 : 16'h0cff;
      cyc(3);
      chk(power_enable, 1'b1);
      clear();
    end
    wr(CMD_OV_FAULT_REACTION, 16'h0000);
    wr(CMD_UV_FAULT_REACTION, 16'h0040);
    for (int ch = 0; ch < 2; ch++) begin
      vin = ch ? 16'h0600 : 16'h0e80;
      cyc(3);
      chk({power_enable, alert_line_n}, 16'h0002);
      vin = 16'h0a00;
      clear();
    end
    summarize();
  end
endmodule : ivfr_top_tb

`default_nettype wire
